/* dpt_pkg.sv */
// constants shared by the dual prescaled down timer
// assumes one system clock; registers reached over apb, one word each
// Overview of operation
// RULE1: count reaching zero sets zero flag bit7
// RULE2: software clears zero flag before new count
// RULE3: request raised while enable bit6 and flag
// RULE4: timer1 bit5 selects pin input or output
// RULE5: bit4 output level or input function
// RULE6: run bit3 low holds prescaler 7fh, stopped
// RULE7: tap code selects divide 1 to 128
// RULE8: timer1 registers at d4h, d3h, d2h
// RULE9: timer2 registers at d7h, d6h, d5h
// RULE10: prescaler register bit7 reads zero
// RULE11: software writes timer2 bit5 as one
// RULE12: prescaler fed by internal/12 or pin
// RULE13: pin mode counts edges or gated ticks
// RULE14: reset: count ffh, prescaler 7fh, control 0
// RULE15: count write beats decrement; 00h sets flag
// RULE16: flag and request held until cleared
// RULE17: counter wraps from zero to ffh
package dpt_pkg;

    // ****************************************
    // register indices, byte address is index times four
    // ****************************************
    localparam logic [7:0] DPT_IDX_T1_PSC = 8'hd2;
    localparam logic [7:0] DPT_IDX_T1_CNT = 8'hd3;
    localparam logic [7:0] DPT_IDX_T1_CTRL = 8'hd4;
    localparam logic [7:0] DPT_IDX_T2_PSC = 8'hd5;
    localparam logic [7:0] DPT_IDX_T2_CNT = 8'hd6;
    localparam logic [7:0] DPT_IDX_T2_CTRL = 8'hd7;
    localparam logic [7:0] DPT_IDX_IRQ_STAT = 8'hd8;
    localparam logic [7:0] DPT_IDX_IRQ_MASK = 8'hd9;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int unsigned DPT_ZERO_BIT = 7;
    localparam int unsigned DPT_IRQEN_BIT = 6;
    localparam int unsigned DPT_DIR_BIT = 5;
    localparam int unsigned DPT_DOUT_BIT = 4;
    localparam int unsigned DPT_RUN_BIT = 3;
    localparam int unsigned DPT_TAP_LSB = 0;
    localparam int unsigned DPT_TAP_W = 3;

    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [7:0] DPT_CNT_RST = 8'hff;
    localparam logic [6:0] DPT_PSC_RST = 7'h7f;
    localparam logic [7:0] DPT_CTRL_RST = 8'h00;
    localparam int unsigned DPT_FINT_DIV = 12;
    localparam int unsigned DPT_TICK_W = 4;

    // ****************************************
    // interrupt status and mask layout
    // ****************************************
    localparam int unsigned DPT_IRQ_T1 = 0;
    localparam int unsigned DPT_IRQ_T2 = 1;
    localparam int unsigned DPT_IRQ_W = 2;

endpackage : dpt_pkg

/* dpt_chan.sv */
// one 8-bit down counter with 7-bit prescaler and control register
// assumes writes are one-cycle strobes and tick_i a one-cycle pulse
`timescale 1ns/1ps
module dpt_chan #(
    parameter bit HAS_PIN = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic pin_i,
    input wire logic wr_ctrl_i,
    input wire logic wr_cnt_i,
    input wire logic wr_psc_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] ctrl_o,
    output logic [7:0] cnt_o,
    output logic [6:0] psc_o,
    output logic zero_evt_o,
    output logic pin_o,
    output logic pin_oe_o
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cnt;
        logic [6:0] timer1_prescaler_value;
        logic pin_prev;
        logic pin_q;
    } dpt_chan_t;

    dpt_chan_t state_reg;
    dpt_chan_t state_next;
    logic run;
    logic src;
    logic psc_dec;
    logic cnt_clk;
    logic hw_zero;
    logic [2:0] tap;
    logic [2:0] tap_idx;

    // ****************************************
    // counting logic
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        run = state_reg.ctrl[dpt_pkg::DPT_RUN_BIT];
        tap = state_reg.ctrl[dpt_pkg::DPT_TAP_LSB +: dpt_pkg::DPT_TAP_W];
        tap_idx = 3'(tap - 3'd1);
        state_next.pin_prev = pin_i;
        if (HAS_PIN && !state_reg.ctrl[dpt_pkg::DPT_DIR_BIT]) // RULE4
        begin
            if (state_reg.ctrl[dpt_pkg::DPT_DOUT_BIT]) // RULE13
                src = tick_i & pin_i;
            else
                src = pin_i & ~state_reg.pin_prev;
        end
        else
        begin
            src = tick_i; // RULE12
        end
        psc_dec = run & src;
        if (!run)
            state_next.timer1_prescaler_value = dpt_pkg::DPT_PSC_RST; // RULE6
        else if (wr_psc_i)
            state_next.timer1_prescaler_value = wdata_i[6:0];
        else if (psc_dec)
            state_next.timer1_prescaler_value = 7'(state_reg.timer1_prescaler_value - 7'h01);
        // tap bit rising edge clocks the counter; tap code 0 clocks it on every prescaler decrement
        if (tap == 3'h0)
            cnt_clk = psc_dec; // RULE7
        else
            cnt_clk = psc_dec & state_next.timer1_prescaler_value[tap_idx] & ~state_reg.timer1_prescaler_value[tap_idx];
        hw_zero = cnt_clk && (state_reg.cnt == 8'h01); // RULE1
        if (cnt_clk)
            state_next.cnt = 8'(state_reg.cnt - 8'h01); // RULE17
        if (wr_cnt_i)
        begin
            state_next.cnt = wdata_i; // RULE15
            hw_zero = (wdata_i == 8'h00);
        end
        if (wr_ctrl_i)
            state_next.ctrl = wdata_i;
        // hardware set wins over a software clear
        state_next.ctrl[dpt_pkg::DPT_ZERO_BIT] =
            state_next.ctrl[dpt_pkg::DPT_ZERO_BIT] | hw_zero; // RULE16
        // latch only in output mode, an input-mode pin keeps its driven level
        if (state_next.ctrl[dpt_pkg::DPT_ZERO_BIT] && !state_reg.ctrl[dpt_pkg::DPT_ZERO_BIT]
            && state_next.ctrl[dpt_pkg::DPT_DIR_BIT])
            state_next.pin_q = state_next.ctrl[dpt_pkg::DPT_DOUT_BIT]; // RULE5
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state_reg <= '{ctrl: dpt_pkg::DPT_CTRL_RST, cnt: dpt_pkg::DPT_CNT_RST,
                           timer1_prescaler_value: dpt_pkg::DPT_PSC_RST, pin_prev: 1'b0, pin_q: 1'b0}; // RULE14
        else if (ce_i)
            state_reg <= state_next;
    end

    assign ctrl_o = state_reg.ctrl;
    assign cnt_o = state_reg.cnt;
    assign psc_o = state_reg.timer1_prescaler_value;
    assign zero_evt_o = ce_i & state_next.ctrl[dpt_pkg::DPT_ZERO_BIT]
                        & ~state_reg.ctrl[dpt_pkg::DPT_ZERO_BIT];
    assign pin_o = HAS_PIN ? state_reg.pin_q : 1'b0;
    assign pin_oe_o = HAS_PIN ? state_reg.ctrl[dpt_pkg::DPT_DIR_BIT] : 1'b0; // RULE4

endmodule : dpt_chan

/* dpt_top.sv */
// dual prescaled down timer with apb register access and interrupt
// assumes apb master and timer pin synchronous to sys_clk_i
`timescale 1ns/1ps
module dpt_top #(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned FINT_DIV = dpt_pkg::DPT_FINT_DIV
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic timer_pin_i,
    output logic timer_pin_o,
    output logic timer_pin_oe_o,
    output logic timer1_irq_o,
    output logic timer2_irq_o,
    output logic irq_o
);

    // ****************************************
    // elaboration checks
    // ****************************************
    generate
        if (ADDR_W < 10)
        begin : g_bad_addr
            $error("address width too small for register map");
        end
        if (FINT_DIV < 2 || FINT_DIV > 15)
        begin : g_bad_div
            $error("internal divider out of range");
        end
    endgenerate

    localparam logic [dpt_pkg::DPT_TICK_W-1:0] TICK_LAST =
        dpt_pkg::DPT_TICK_W'(FINT_DIV - 1);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [dpt_pkg::DPT_TICK_W-1:0] tick_cnt;
        logic [31:0] prdata;
        logic slverr;
        logic [dpt_pkg::DPT_IRQ_W-1:0] stat;
        logic [dpt_pkg::DPT_IRQ_W-1:0] mask;
    } dpt_top_t;

    dpt_top_t state_reg;
    dpt_top_t state_next;

    logic setup;
    logic access;
    logic wr_acc;
    logic tick;
    logic hit_t1_psc;
    logic hit_t1_cnt;
    logic hit_t1_ctrl;
    logic hit_t2_psc;
    logic hit_t2_cnt;
    logic hit_t2_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_any;
    logic [31:0] rd_mux;
    logic [7:0] wbyte;
    logic [7:0] t1_ctrl;
    logic [7:0] t1_cnt;
    logic [6:0] t1_psc;
    logic [7:0] t2_ctrl;
    logic [7:0] t2_cnt;
    logic [6:0] t2_psc;
    logic t1_zero_evt;
    logic t2_zero_evt;
    logic [dpt_pkg::DPT_IRQ_W-1:0] evt;
    logic [dpt_pkg::DPT_IRQ_W-1:0] clr;

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == ADDR_W'({idx, 2'b00}));
    endfunction : hit

    always_comb
    begin
        hit_t1_psc = hit(paddr_i, dpt_pkg::DPT_IDX_T1_PSC); // RULE8
        hit_t1_cnt = hit(paddr_i, dpt_pkg::DPT_IDX_T1_CNT); // RULE8
        hit_t1_ctrl = hit(paddr_i, dpt_pkg::DPT_IDX_T1_CTRL); // RULE8
        hit_t2_psc = hit(paddr_i, dpt_pkg::DPT_IDX_T2_PSC); // RULE9
        hit_t2_cnt = hit(paddr_i, dpt_pkg::DPT_IDX_T2_CNT); // RULE9
        hit_t2_ctrl = hit(paddr_i, dpt_pkg::DPT_IDX_T2_CTRL); // RULE9
        hit_stat = hit(paddr_i, dpt_pkg::DPT_IDX_IRQ_STAT);
        hit_mask = hit(paddr_i, dpt_pkg::DPT_IDX_IRQ_MASK);
        hit_any = hit_t1_psc | hit_t1_cnt | hit_t1_ctrl | hit_t2_psc | hit_t2_cnt
                  | hit_t2_ctrl | hit_stat | hit_mask;
    end

    // ****************************************
    // apb phases
    // ****************************************
    assign setup = psel_i & ~penable_i;
    assign access = psel_i & penable_i;
    // write lands only on the completing edge
    assign wr_acc = access & pwrite_i & ce_i & ~state_reg.slverr;
    // byte lane 0 carries every register
    assign wbyte = pstrb_i[0] ? pwdata_i[7:0] : rd_mux[7:0];

    // ****************************************
    // read data mux
    // ****************************************
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_t1_psc)
            rd_mux = {25'h000_0000, t1_psc}; // RULE10
        else if (hit_t1_cnt)
            rd_mux = {24'h00_0000, t1_cnt};
        else if (hit_t1_ctrl)
            rd_mux = {24'h00_0000, t1_ctrl};
        else if (hit_t2_psc)
            rd_mux = {25'h000_0000, t2_psc}; // RULE10
        else if (hit_t2_cnt)
            rd_mux = {24'h00_0000, t2_cnt};
        else if (hit_t2_ctrl)
            rd_mux = {24'h00_0000, t2_ctrl};
        else if (hit_stat)
            rd_mux = {30'h0000_0000, state_reg.stat};
        else if (hit_mask)
            rd_mux = {30'h0000_0000, state_reg.mask};
    end

    // ****************************************
    // internal clock divided by FINT_DIV, twelve by default
    // ****************************************
    assign tick = (state_reg.tick_cnt == TICK_LAST); // RULE12

    // ****************************************
    // timer channels
    // ****************************************
    dpt_chan #(
        .HAS_PIN(1'b1)
    ) u_timer1 (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .pin_i(timer_pin_i),
        .wr_ctrl_i(wr_acc & hit_t1_ctrl),
        .wr_cnt_i(wr_acc & hit_t1_cnt),
        .wr_psc_i(wr_acc & hit_t1_psc),
        .wdata_i(wbyte),
        .ctrl_o(t1_ctrl),
        .cnt_o(t1_cnt),
        .psc_o(t1_psc),
        .zero_evt_o(t1_zero_evt),
        .pin_o(timer_pin_o),
        .pin_oe_o(timer_pin_oe_o)
    );

    dpt_chan #(
        .HAS_PIN(1'b0)
    ) u_timer2 (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .pin_i(1'b0),
        .wr_ctrl_i(wr_acc & hit_t2_ctrl),
        .wr_cnt_i(wr_acc & hit_t2_cnt),
        .wr_psc_i(wr_acc & hit_t2_psc),
        .wdata_i(wbyte),
        .ctrl_o(t2_ctrl),
        .cnt_o(t2_cnt),
        .psc_o(t2_psc),
        .zero_evt_o(t2_zero_evt),
        .pin_o(),
        .pin_oe_o()
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        if (tick)
            state_next.tick_cnt = '0;
        else
            state_next.tick_cnt = dpt_pkg::DPT_TICK_W'(state_reg.tick_cnt + 1'b1);
        // read data and error captured in setup, presented in access
        if (setup)
        begin
            state_next.prdata = pwrite_i ? 32'h0000_0000 : rd_mux;
            state_next.slverr = ~hit_any;
        end
        evt = '0;
        evt[dpt_pkg::DPT_IRQ_T1] = t1_zero_evt;
        evt[dpt_pkg::DPT_IRQ_T2] = t2_zero_evt;
        clr = '0;
        if (wr_acc && hit_stat)
            clr = wbyte[dpt_pkg::DPT_IRQ_W-1:0];
        // a new event wins over a simultaneous clear
        state_next.stat = (state_reg.stat & ~clr) | evt;
        if (wr_acc && hit_mask)
            state_next.mask = wbyte[dpt_pkg::DPT_IRQ_W-1:0];
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state_reg <= '{tick_cnt: '0, prdata: 32'h0000_0000, slverr: 1'b0,
                           stat: '0, mask: '0};
        else if (ce_i)
            state_reg <= state_next;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata_o = state_reg.prdata;
    // a frozen block stretches the access phase
    assign pready_o = ce_i;
    assign pslverr_o = access & state_reg.slverr;
    assign timer1_irq_o = t1_ctrl[dpt_pkg::DPT_ZERO_BIT]
                          & t1_ctrl[dpt_pkg::DPT_IRQEN_BIT]; // RULE3
    assign timer2_irq_o = t2_ctrl[dpt_pkg::DPT_ZERO_BIT]
                          & t2_ctrl[dpt_pkg::DPT_IRQEN_BIT]; // RULE3
    assign irq_o = |(state_reg.stat & state_reg.mask);

endmodule : dpt_top

/* dpt_props.sv */
// assertion checker for the dual prescaled down timer top ports
// assumes it is bound onto dpt_top and sees one clock domain
`timescale 1ns/1ps
module dpt_props #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic timer_pin_o,
    input wire logic timer_pin_oe_o,
    input wire logic timer1_irq_o,
    input wire logic timer2_irq_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic acc;
    logic wr;
    logic mapped;
    assign acc = psel_i && penable_i;
    assign wr = acc && pwrite_i && ce_i;
    assign mapped = paddr_i >= 'h348 && paddr_i <= 'h364 && paddr_i[1:0] == 2'h0;
    a_ready_is_ce: assert property (pready_o == ce_i)
        else $error("pready does not follow clock enable");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr_o)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr_o)
        else $error("mapped access flagged as error");
    a_err_in_access: assert property (pslverr_o |-> acc)
        else $error("error outside access phase");
    a_psc_top_zero: assert property (acc && !pwrite_i && paddr_i == 'h348 |-> !prdata_o[7])
        else $error("prescaler bit 7 read as one");
    a_t1_irq_held: assert property (timer1_irq_o && !wr |=> timer1_irq_o)
        else $error("timer 1 request dropped without a write");
    a_t2_irq_held: assert property (timer2_irq_o && !wr |=> timer2_irq_o)
        else $error("timer 2 request dropped without a write");
    a_oe_by_write: assert property ($rose(timer_pin_oe_o) |->
        $past(wr && paddr_i == 'h350 && pwdata_i[5]))
        else $error("pin enabled without a direction write");
    a_pin_out_mode: assert property ($changed(timer_pin_o) |-> timer_pin_oe_o)
        else $error("pin value changed in input mode");
endmodule : dpt_props

bind dpt_top dpt_props #(.ADDR_W(ADDR_W)) u_props (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .timer_pin_o(timer_pin_o),
    .timer_pin_oe_o(timer_pin_oe_o), .timer1_irq_o(timer1_irq_o),
    .timer2_irq_o(timer2_irq_o));

/* dpt_pin_model.sv */
// external source on the timer 1 pin: edge bursts or one high level
// assumes the pin rests low between bursts
`timescale 1ns/1ps
module dpt_pin_model (
    input wire logic sys_clk_i,
    output logic pin_o
);
    // ****************************************
    // pin stimulus
    // ****************************************
    initial pin_o = 1'b0;
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge sys_clk_i);
            pin_o <= 1'b1;
            repeat (2) @(posedge sys_clk_i);
            pin_o <= 1'b0;
            @(posedge sys_clk_i);
        end
    endtask : pulses
    task automatic level(input int n);
        @(posedge sys_clk_i);
        pin_o <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        pin_o <= 1'b0;
    endtask : level
endmodule : dpt_pin_model

/* dpt_top_tb.sv */
// self-checking bench for the dual prescaled down timer
// assumes 250 MHz clock, apb master tasks, pin model on timer 1
`timescale 1ns/1ps
module dpt_top_tb;
    // ****************************************
    // bench
    // ****************************************
    localparam int DIV = 8;
    localparam logic [11:0] T1P = {2'b00, dpt_pkg::DPT_IDX_T1_PSC, 2'b00};
    localparam logic [11:0] T1N = {2'b00, dpt_pkg::DPT_IDX_T1_CNT, 2'b00};
    localparam logic [11:0] T1C = {2'b00, dpt_pkg::DPT_IDX_T1_CTRL, 2'b00};
    localparam logic [11:0] T2N = {2'b00, dpt_pkg::DPT_IDX_T2_CNT, 2'b00};
    localparam logic [11:0] T2C = {2'b00, dpt_pkg::DPT_IDX_T2_CTRL, 2'b00};
    localparam logic [11:0] STA = {2'b00, dpt_pkg::DPT_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] MSK = {2'b00, dpt_pkg::DPT_IDX_IRQ_MASK, 2'b00};
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, timer_pin_i, timer_pin_o, timer_pin_oe_o;
    logic timer1_irq_o, timer2_irq_o, irq_o, err;
    logic [31:0] rd;
    int err_count = 0;
    int total_checks = 0;
    int n;
    always #2 sys_clk_i = ~sys_clk_i;
    dpt_top #(.FINT_DIV(DIV)) u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .timer_pin_i(timer_pin_i),
        .timer_pin_o(timer_pin_o), .timer_pin_oe_o(timer_pin_oe_o),
        .timer1_irq_o(timer1_irq_o), .timer2_irq_o(timer2_irq_o), .irq_o(irq_o));
    dpt_pin_model u_pin (.sys_clk_i(sys_clk_i), .pin_o(timer_pin_i));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // setup, access until pready seen at a rising edge, release; returns at a falling edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        @(posedge sys_clk_i);
        while (pready_o !== 1'b1)
            @(posedge sys_clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask : rdc
    initial
    begin
        #100000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            rdc(T1P + 12'(12 * i), 32'h7f, "reset psc");
            rdc(T1N + 12'(12 * i), 32'hff, "reset cnt");
            rdc(T1C + 12'(12 * i), 32'h0, "reset ctrl");
        end
        $display("test reset done");
        apb(1'b1, T1N, 32'h5a);
        apb(1'b1, T2N, 32'ha5);
        apb(1'b1, T1C, 32'h05);
        repeat (40) @(negedge sys_clk_i);
        rdc(T1N, 32'h5a, "t1 cnt rw");
        rdc(T2N, 32'ha5, "t2 cnt rw");
        rdc(T1P, 32'h7f, "stopped psc");
        apb(1'b0, 12'h400, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        @(negedge sys_clk_i);
        chk("ready while frozen", {31'h0, pready_o}, 32'h0);
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        $display("test access done");
        apb(1'b1, MSK, 32'h1);
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, T1C, 32'h0);
            apb(1'b1, T1N, 32'h2);
            apb(1'b1, T1C, 32'h68 | k);
            n = 0;
            while (timer1_irq_o !== 1'b1 && n < 3000)
            begin
                @(negedge sys_clk_i);
                n++;
            end
            chk("tap low", 32'(n >= (2 ** (k + 1) - 1) * DIV - 4), 32'h1);
            chk("tap high", 32'(n <= (2 ** (k + 1)) * DIV + 4), 32'h1);
            chk("irq out", {31'h0, irq_o}, 32'h1);
            if (k == 0)
            begin
                repeat (10) @(negedge sys_clk_i);
                rdc(T1N, 32'hff, "wrap");
            end
            rdc(T1C, 32'he8 | k, "zero flag");
        end
        apb(1'b1, T1C, 32'h0);
        apb(1'b1, STA, 32'h3);
        rdc(STA, 32'h0, "status clear");
        chk("irq cleared", {31'h0, irq_o}, 32'h0);
        $display("test taps done");
        apb(1'b1, MSK, 32'h0);
        apb(1'b1, T1C, 32'h40);
        apb(1'b1, T1N, 32'h0);
        rdc(T1C, 32'hc0, "zero write flag");
        chk("t1 irq", {31'h0, timer1_irq_o}, 32'h1);
        rdc(STA, 32'h1, "status set");
        chk("masked irq", {31'h0, irq_o}, 32'h0);
        apb(1'b1, T2C, 32'he0);
        rdc(T2C, 32'he0, "bit7 write flag");
        chk("t2 irq", {31'h0, timer2_irq_o}, 32'h1);
        apb(1'b1, T2C, 32'ha0);
        chk("t2 irq disabled", {31'h0, timer2_irq_o}, 32'h0);
        apb(1'b1, STA, 32'h3);
        $display("test flags done");
        apb(1'b1, T1C, 32'h30);
        chk("pin oe", {31'h0, timer_pin_oe_o}, 32'h1);
        chk("pin idle", {31'h0, timer_pin_o}, 32'h0);
        apb(1'b1, T1N, 32'h0);
        chk("pin high", {31'h0, timer_pin_o}, 32'h1);
        apb(1'b1, T1C, 32'h20);
        apb(1'b1, T1N, 32'h0);
        chk("pin low", {31'h0, timer_pin_o}, 32'h0);
        apb(1'b1, T1C, 32'h0);
        chk("pin input", {31'h0, timer_pin_oe_o}, 32'h0);
        $display("test output done");
        apb(1'b1, T1C, 32'h08);
        apb(1'b1, T1P, 32'h25);
        rdc(T1P, 32'h25, "psc rw");
        apb(1'b1, T1N, 32'h10);
        u_pin.pulses(5);
        repeat (4) @(negedge sys_clk_i);
        rdc(T1N, 32'h0b, "event count");
        rdc(T1P, 32'h20, "psc after edges");
        apb(1'b1, T1C, 32'h18);
        apb(1'b1, T1N, 32'h10);
        repeat (40) @(negedge sys_clk_i);
        rdc(T1N, 32'h10, "gate closed");
        u_pin.level(4 * DIV);
        repeat (4) @(negedge sys_clk_i);
        apb(1'b0, T1N, 32'h0);
        chk("gate open", rd, 32'h0c);
        $display("test input done");
        end_of_test();
    end
endmodule : dpt_top_tb
